// >>> verilog/cpa_pkg.sv
// Constants and carrier types for the complementary PWM auxiliary control block
package cpa_pkg;
   localparam int unsigned CPA_AW = 8;
   localparam int unsigned CPA_DW = 32;
   // Register byte offsets
   localparam logic [7:0] CPA_OFF_WAVE = 8'h00;
   localparam logic [7:0] CPA_OFF_OUTC = 8'h04;
   localparam logic [7:0] CPA_OFF_GATE = 8'h08;
   localparam logic [7:0] CPA_OFF_IEN = 8'h0c;
   localparam logic [7:0] CPA_OFF_SKIP = 8'h10;
   localparam logic [7:0] CPA_OFF_BUFX = 8'h14;
   localparam logic [7:0] CPA_OFF_ADCR = 8'h18;
   localparam logic [7:0] CPA_OFF_ACC = 8'h1c;
   localparam logic [7:0] CPA_OFF_SYNC = 8'h20;
   localparam logic [7:0] CPA_OFF_BUF = 8'h24;
   localparam logic [7:0] CPA_OFF_TEMP = 8'h28;
   localparam logic [7:0] CPA_OFF_STAT = 8'h2c;
   // Field positions
   localparam int unsigned CPA_WAVE_CTRL = 0;
   localparam int unsigned CPA_WAVE_CCE = 1;
   localparam int unsigned CPA_OUTC_NEG = 0;
   localparam int unsigned CPA_OUTC_POS = 1;
   localparam int unsigned CPA_OUTC_TOG = 2;
   localparam int unsigned CPA_GATE_U = 0;
   localparam int unsigned CPA_GATE_FB = 3;
   localparam int unsigned CPA_GATE_P = 4;
   localparam int unsigned CPA_GATE_N = 5;
   localparam int unsigned CPA_IEN_CREST = 0;
   localparam int unsigned CPA_IEN_TROUGH = 1;
   localparam int unsigned CPA_IEN_TRG = 2;
   localparam int unsigned CPA_IEN_TRG2 = 3;
   localparam int unsigned CPA_SKIP_TIMER_COUNTER = 0;
   localparam int unsigned CPA_SKIP_TEN = 3;
   localparam int unsigned CPA_SKIP_CCNT = 4;
   localparam int unsigned CPA_SKIP_CEN = 7;
   localparam int unsigned CPA_ADCR_CREST = 0;
   localparam int unsigned CPA_ADCR_TROUGH = 1;
   // Buffer transfer control encodings
   localparam logic [1:0] CPA_BTE_NORMAL = 2'h0;
   localparam logic [1:0] CPA_BTE_OFF = 2'h1;
   localparam logic [1:0] CPA_BTE_LINK = 2'h2;
   // Reset values
   localparam logic [7:0] CPA_RST_OUTC = 8'h03;
   localparam logic CPA_RST_ACC = 1'b1;
   // Events from the waveform engine, all one-cycle pulses except the levels tb_trough and init_period
   typedef struct packed {
      logic crest;
      logic trough;
      logic sync_clr;
      logic other_cmp;
      logic delay_req;
      logic xfer_req;
      logic tb_trough;
      logic init_period;
   } cpa_evt_t;
   typedef struct packed {
      logic [2:0] pos;
      logic [2:0] neg;
   } cpa_phase_t;
endpackage

// >>> verilog/cpa_aux_ctrl.sv
// Complementary PWM auxiliary control: clearing, commutation, triggers, skipping, protection
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpa_aux_ctrl
   import cpa_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Register port
   input wire logic [CPA_AW-1:0] i_addr,
   input wire logic [CPA_DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [CPA_DW-1:0] o_rdata,
   // Waveform engine
   input wire cpa_evt_t i_evt,
   input wire cpa_phase_t i_pwm,
   output logic o_cnt_clear,
   output logic o_init_load,
   output logic o_buf_xfer,
   output logic [15:0] o_temp,
   // Interrupts and A/D requests
   output logic o_crest_irq,
   output logic o_trough_irq,
   output logic o_adc_req,
   output logic o_adc_delay_req,
   // Pins
   input wire logic [2:0] i_position,
   input wire logic i_shutdown,
   input wire logic i_osc_stop,
   output cpa_phase_t o_gate,
   output logic [5:0] o_gate_oe
);
   typedef struct packed {
      logic wave_ctrl;
      logic cce;
      logic [2:0] outc;
      logic [5:0] gate;
      logic [3:0] ien;
      logic [7:0] skip;
      logic [1:0] buffer_transfer_ctrl_field;
      logic [1:0] adcr;
      logic acc;
      logic sync_en;
      logic [15:0] buf_r;
      logic [15:0] temp;
      logic [2:0] crest_cnt;
      logic [2:0] trough_cnt;
      logic crest_win;
      logic trough_win;
      logic [2:0] pos_s1;
      logic [2:0] pos_s2;
      logic [2:0] pos_prev;
      logic [1:0] halt_s1;
      logic [1:0] halt_s2;
      cpa_phase_t pattern;
      cpa_phase_t gate_out;
      logic clr;
      logic init_load;
      logic xfer;
      logic crest_irq;
      logic trough_irq;
      logic adc;
      logic adc_dly;
      logic [CPA_DW-1:0] rdata;
   } cpa_state_t;

   cpa_state_t s_q;
   cpa_state_t s_d;
   logic [1:0] rst_sync_q;
   logic rst_n;

   // Reset release
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Commutation table: position code to on phases
   function automatic cpa_phase_t commutate(input logic [2:0] code);
      cpa_phase_t r;
      r = '0;
      unique case (code)
         3'h1: begin
            r.pos = 3'h1;
            r.neg = 3'h2;
         end
         3'h3: begin
            r.pos = 3'h1;
            r.neg = 3'h4;
         end
         3'h2: begin
            r.pos = 3'h2;
            r.neg = 3'h4;
         end
         3'h6: begin
            r.pos = 3'h2;
            r.neg = 3'h1;
         end
         3'h4: begin
            r.pos = 3'h4;
            r.neg = 3'h1;
         end
         3'h5: begin
            r.pos = 3'h4;
            r.neg = 3'h2;
         end
         default: r = '0;
      endcase
      return r;
   endfunction

   logic wr_ok;
   logic sync_clr;
   logic c_pass;
   logic t_pass;
   logic c_live;
   logic t_live;
   logic xfer_ok;
   logic pos_lvl;
   logic neg_lvl;
   logic halted;

   always_comb begin
      s_d = s_q;
      wr_ok = s_q.acc;
      pos_lvl = s_q.outc[CPA_OUTC_POS];
      neg_lvl = s_q.outc[CPA_OUTC_NEG];
      c_live = s_q.skip[CPA_SKIP_CEN] && (s_q.skip[CPA_SKIP_CCNT +: 3] != 3'h0);
      t_live = s_q.skip[CPA_SKIP_TEN] && (s_q.skip[CPA_SKIP_TIMER_COUNTER +: 3] != 3'h0);
      c_pass = 1'b0;
      t_pass = 1'b0;
      xfer_ok = 1'b0;
      halted = s_q.halt_s2[0] || s_q.halt_s2[1];
      // Register writes
      if (i_wr) begin
         if (i_addr == CPA_OFF_ACC) begin
            s_d.acc = i_wdata[0];
         end
         if (i_addr == CPA_OFF_BUF) begin
            s_d.buf_r = i_wdata[15:0];
         end
         if (i_addr == CPA_OFF_SKIP) begin
            s_d.skip = i_wdata[7:0];
         end
         if (i_addr == CPA_OFF_BUFX) begin
            s_d.buffer_transfer_ctrl_field = i_wdata[1:0];
         end
         if (i_addr == CPA_OFF_ADCR) begin
            s_d.adcr = i_wdata[1:0];
         end
         if (wr_ok) begin
            unique case (i_addr)
               CPA_OFF_WAVE: begin
                  s_d.wave_ctrl = i_wdata[CPA_WAVE_CTRL];
                  s_d.cce = i_wdata[CPA_WAVE_CCE];
               end
               CPA_OFF_OUTC: s_d.outc = i_wdata[2:0];
               CPA_OFF_GATE: s_d.gate = i_wdata[5:0];
               CPA_OFF_IEN: s_d.ien = i_wdata[3:0];
               CPA_OFF_SYNC: s_d.sync_en = i_wdata[0];
               default: s_d.sync_en = s_q.sync_en;
            endcase
         end
      end
      // Read data, valid the cycle after the strobe
      s_d.rdata = '0;
      if (i_rd) begin
         unique case (i_addr)
            CPA_OFF_WAVE: s_d.rdata = wr_ok ? {30'h0, s_q.cce, s_q.wave_ctrl} : '0;
            CPA_OFF_OUTC: s_d.rdata = wr_ok ? {29'h0, s_q.outc} : '0;
            CPA_OFF_GATE: s_d.rdata = wr_ok ? {26'h0, s_q.gate} : '0;
            CPA_OFF_IEN: s_d.rdata = wr_ok ? {28'h0, s_q.ien} : '0;
            CPA_OFF_SYNC: s_d.rdata = wr_ok ? {31'h0, s_q.sync_en} : '0;
            CPA_OFF_SKIP: s_d.rdata = {24'h0, s_q.skip};
            CPA_OFF_BUFX: s_d.rdata = {30'h0, s_q.buffer_transfer_ctrl_field};
            CPA_OFF_ADCR: s_d.rdata = {30'h0, s_q.adcr};
            CPA_OFF_ACC: s_d.rdata = {31'h0, s_q.acc};
            CPA_OFF_BUF: s_d.rdata = {16'h0, s_q.buf_r};
            CPA_OFF_TEMP: s_d.rdata = {16'h0, s_q.temp};
            CPA_OFF_STAT: s_d.rdata = {14'h0, halted, s_q.pos_s2, s_q.trough_win, s_q.crest_win,
                                       s_q.trough_cnt, s_q.crest_cnt, s_q.pattern};
            default: s_d.rdata = '0;
         endcase
      end
      // Counter clearing
      sync_clr = i_evt.sync_clr && s_q.sync_en;
      s_d.clr = sync_clr || (s_q.cce && i_evt.crest);
      s_d.init_load = sync_clr && !(s_q.wave_ctrl && i_evt.tb_trough && !i_evt.init_period);
      // Skip counters
      if (!s_q.skip[CPA_SKIP_CEN]) begin
         s_d.crest_cnt = 3'h0;
      end else if (i_evt.crest) begin
         if (s_q.crest_cnt + 3'h1 >= s_q.skip[CPA_SKIP_CCNT +: 3]) begin
            s_d.crest_cnt = 3'h0;
            c_pass = 1'b1;
         end else begin
            s_d.crest_cnt = s_q.crest_cnt + 3'h1;
         end
      end
      if (!s_q.skip[CPA_SKIP_TEN]) begin
         s_d.trough_cnt = 3'h0;
      end else if (i_evt.trough) begin
         if (s_q.trough_cnt + 3'h1 >= s_q.skip[CPA_SKIP_TIMER_COUNTER +: 3]) begin
            s_d.trough_cnt = 3'h0;
            t_pass = 1'b1;
         end else begin
            s_d.trough_cnt = s_q.trough_cnt + 3'h1;
         end
      end
      s_d.crest_irq = i_evt.crest && s_q.ien[CPA_IEN_CREST] &&
                      (!s_q.skip[CPA_SKIP_CEN] || c_pass);
      s_d.trough_irq = i_evt.trough && s_q.ien[CPA_IEN_TROUGH] &&
                       (!s_q.skip[CPA_SKIP_TEN] || t_pass);
      // Transfer-enabled periods: from a passed event until the next event of either kind
      if (i_evt.crest || i_evt.trough) begin
         s_d.crest_win = c_pass && c_live;
         s_d.trough_win = t_pass && t_live;
      end
      // Buffer transfer
      unique case (s_q.buffer_transfer_ctrl_field)
         CPA_BTE_NORMAL: xfer_ok = 1'b1;
         CPA_BTE_OFF: xfer_ok = 1'b0;
         CPA_BTE_LINK: xfer_ok = (s_q.crest_win && c_live) || (s_q.trough_win && t_live);
         default: xfer_ok = 1'b0;
      endcase
      s_d.xfer = i_evt.xfer_req && xfer_ok;
      if (s_d.xfer) begin
         s_d.temp = s_q.buf_r;
      end
      // A/D start requests
      s_d.adc = s_q.ien[CPA_IEN_TRG] && (i_evt.crest || i_evt.other_cmp ||
                (i_evt.trough && s_q.ien[CPA_IEN_TRG2]));
      s_d.adc_dly = i_evt.delay_req &&
                    (!(s_q.adcr[CPA_ADCR_CREST] || s_q.adcr[CPA_ADCR_TROUGH]) ||
                     (s_q.adcr[CPA_ADCR_CREST] && s_q.crest_win) ||
                     (s_q.adcr[CPA_ADCR_TROUGH] && s_q.trough_win));
      // Pin synchronisers
      s_d.pos_s1 = i_position;
      s_d.pos_s2 = s_q.pos_s1;
      s_d.pos_prev = s_q.pos_s2;
      s_d.halt_s1 = {i_osc_stop, i_shutdown};
      s_d.halt_s2 = s_q.halt_s1;
      // Commutation pattern
      if (s_q.gate[CPA_GATE_FB]) begin
         s_d.pattern = commutate(s_q.gate[CPA_GATE_U +: 3]);
      end else if (s_q.pos_s2 != s_q.pos_prev) begin
         s_d.pattern = commutate(s_q.pos_s2);
      end
      // Gate drive: on phases chop or hold on level, off phases hold the inactive level
      for (int k = 0; k < 3; k++) begin
         if (s_q.pattern.pos[k]) begin
            s_d.gate_out.pos[k] = s_q.gate[CPA_GATE_P] ? (i_pwm.pos[k] ~^ pos_lvl) : pos_lvl;
         end else begin
            s_d.gate_out.pos[k] = !pos_lvl;
         end
         if (s_q.pattern.neg[k]) begin
            s_d.gate_out.neg[k] = s_q.gate[CPA_GATE_N] ? (i_pwm.neg[k] ~^ neg_lvl) : neg_lvl;
         end else begin
            s_d.gate_out.neg[k] = !neg_lvl;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.outc <= CPA_RST_OUTC[2:0];
         s_q.acc <= CPA_RST_ACC;
         s_q.gate_out <= {3'h0, 3'h0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_cnt_clear = s_q.clr;
   assign o_init_load = s_q.init_load;
   assign o_buf_xfer = s_q.xfer;
   assign o_temp = s_q.temp;
   assign o_crest_irq = s_q.crest_irq;
   assign o_trough_irq = s_q.trough_irq;
   assign o_adc_req = s_q.adc;
   assign o_adc_delay_req = s_q.adc_dly;
   assign o_gate = s_q.gate_out;
   assign o_gate_oe = (s_q.halt_s2[0] || s_q.halt_s2[1]) ? 6'h00 : 6'h3f;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!rst_n);

   AST_SUPPRESS: assert property (s_q.wave_ctrl && s_q.sync_en && i_evt.sync_clr && i_evt.tb_trough
      && !i_evt.init_period |=> !o_init_load) else $error("initial output not suppressed");
   AST_INIT_OUT: assert property (s_q.sync_en && i_evt.sync_clr && !i_evt.tb_trough |=> o_init_load)
      else $error("initial output missing");
   AST_INIT_START: assert property (s_q.sync_en && i_evt.sync_clr && i_evt.init_period |=> o_init_load)
      else $error("initial output suppressed at start");
   AST_SYNC_CLR: assert property (s_q.sync_en && i_evt.sync_clr |=> o_cnt_clear)
      else $error("sync clear lost");
   AST_CCE_CLR: assert property (o_cnt_clear |-> $past(i_evt.sync_clr && s_q.sync_en) ||
      $past(s_q.cce && i_evt.crest)) else $error("unexpected counter clear");
   AST_HALL: assert property (!s_q.gate[CPA_GATE_FB] && $stable(s_q.pos_s2) && $stable(s_q.gate)
      ##1 $stable(s_q.pos_s2) |-> $stable(s_q.pattern)) else $error("pattern moved without edge");
   AST_SWBITS: assert property (s_q.gate[CPA_GATE_FB] |=> s_q.pattern == commutate($past(s_q.gate[2:0])))
      else $error("pattern not following drive bits");
   AST_LEVEL: assert property (s_q.pattern.pos[0] && !s_q.gate[CPA_GATE_P] |=>
      o_gate.pos[0] == $past(s_q.outc[CPA_OUTC_POS])) else $error("on level wrong");
   AST_ADC_EN: assert property (!s_q.ien[CPA_IEN_TRG] |=> !o_adc_req)
      else $error("adc request while disabled");
   AST_ADC_TROUGH: assert property (s_q.ien[CPA_IEN_TRG] && !s_q.ien[CPA_IEN_TRG2] && i_evt.trough
      && !i_evt.crest && !i_evt.other_cmp |=> !o_adc_req) else $error("trough adc without enable");
   AST_SKIP: assert property (s_q.skip[CPA_SKIP_CEN] && s_q.ien[CPA_IEN_CREST] && i_evt.crest &&
      (s_q.crest_cnt + 3'h1 < s_q.skip[CPA_SKIP_CCNT +: 3]) |=> !o_crest_irq) else $error("crest not skipped");
   AST_SKIP_RST: assert property (!s_q.skip[CPA_SKIP_CEN] |=> s_q.crest_cnt == 3'h0)
      else $error("skip counter not reset");
   AST_NO_XFER: assert property (s_q.buffer_transfer_ctrl_field == CPA_BTE_OFF |=> !o_buf_xfer)
      else $error("transfer while disabled");
   AST_LINK: assert property (s_q.buffer_transfer_ctrl_field == CPA_BTE_LINK && !c_live && !t_live && !s_q.crest_win
      && !s_q.trough_win |=> !o_buf_xfer) else $error("linked transfer outside period");
   AST_LINK_OFF: assert property (s_q.buffer_transfer_ctrl_field == CPA_BTE_LINK && !c_live && !t_live |=> !o_buf_xfer)
      else $error("linked transfer with skipping disabled");
   AST_TEMP: assert property (s_q.buffer_transfer_ctrl_field == CPA_BTE_OFF |=> $stable(o_temp))
      else $error("temporary value changed while transfer off");
   AST_DLY_OPEN: assert property (i_evt.delay_req && s_q.adcr == 2'h0 |=> o_adc_delay_req)
      else $error("unlinked delayed request lost");
   AST_ADC_CREST: assert property (s_q.ien[CPA_IEN_TRG] && i_evt.crest |=> o_adc_req)
      else $error("crest adc request lost");
   AST_GATE_OFF: assert property (!s_q.pattern.neg[0] |=> o_gate.neg[0] == !$past(s_q.outc[CPA_OUTC_NEG]))
      else $error("off level wrong");
   AST_TROUGH_SKIP: assert property (s_q.skip[CPA_SKIP_TEN] && s_q.ien[CPA_IEN_TROUGH] && i_evt.trough &&
      (s_q.trough_cnt + 3'h1 < s_q.skip[CPA_SKIP_TIMER_COUNTER +: 3]) |=> !o_trough_irq) else $error("trough not skipped");
   AST_PROT: assert property (!s_q.acc && i_wr && i_addr == CPA_OFF_GATE |=> $stable(s_q.gate))
      else $error("protected write taken");
   AST_HIZ: assert property (s_q.halt_s2 != 2'h0 |-> o_gate_oe == 6'h00)
      else $error("outputs not released");
   AST_DLY: assert property (i_evt.delay_req && s_q.adcr != 2'h0 && !s_q.crest_win &&
      !s_q.trough_win |=> !o_adc_delay_req) else $error("delayed request not skipped");

   COV_CLR: cover property (o_cnt_clear ##1 o_init_load);
   COV_SKIP: cover property (s_q.crest_cnt == 3'h2 ##[1:50] o_crest_irq);
   COV_XFER: cover property (s_q.buffer_transfer_ctrl_field == CPA_BTE_LINK && o_buf_xfer);
   COV_HIZ: cover property (o_gate_oe == 6'h00);
   COV_HALL: cover property (o_gate_oe == 6'h3f && s_q.pos_s2 != s_q.pos_prev);
endmodule
`default_nettype wire

// >>> dv/cpa_hall_model.sv
// Hall position sensors and power stage fault source facing the block
`timescale 1ns/1ps
`default_nettype none
module cpa_hall_model (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Bench control
   input wire logic i_step,
   input wire logic i_trip,
   // Sensor and fault pins
   output logic [2:0] o_position,
   output logic o_shutdown
);
   logic [2:0] idx_q;
   // Rotor advances one sector per step
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idx_q <= 3'h0;
      end else if (i_step) begin
         idx_q <= (idx_q == 3'h5) ? 3'h0 : idx_q + 3'h1;
      end
   end
   // Sector to sensor code, one bit changes per step
   always_comb begin
      case (idx_q)
         3'h0: o_position = 3'h1;
         3'h1: o_position = 3'h3;
         3'h2: o_position = 3'h2;
         3'h3: o_position = 3'h6;
         3'h4: o_position = 3'h4;
         default: o_position = 3'h5;
      endcase
   end
   // Stage fault raises the shutdown line
   assign o_shutdown = i_trip;
endmodule
`default_nettype wire

// >>> dv/cpa_aux_ctrl_bench.sv
// Self-checking testbench for the complementary PWM auxiliary control block
`timescale 1ns/1ps
`default_nettype none
module cpa_aux_ctrl_bench
   import cpa_pkg::*;
;
   localparam logic [7:0] EV_CREST = 8'h80;
   localparam logic [7:0] EV_TROUGH = 8'h40;
   localparam logic [7:0] EV_SYNC = 8'h20;
   localparam logic [7:0] EV_OTHER = 8'h10;
   localparam logic [7:0] EV_DELAY = 8'h08;
   localparam logic [7:0] EV_XFER = 8'h04;
   localparam logic [5:0] HALL_TAB [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [CPA_AW-1:0] addr = '0;
   logic [CPA_DW-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   cpa_evt_t evt = '0;
   logic [7:0] lv = 8'h00;
   cpa_phase_t pwm = '0;
   logic step = 1'b0;
   logic trip = 1'b0;
   logic osc_stop = 1'b0;
   logic [CPA_DW-1:0] rdata;
   logic cnt_clear, init_load, buf_xfer, crest_irq, trough_irq, adc_req, adc_dreq, shutdown;
   logic [15:0] temp;
   logic [2:0] position;
   cpa_phase_t gate;
   logic [5:0] gate_oe;
   int miscompares = 0;
   int checks_done = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   cpa_aux_ctrl u_cpa_aux_ctrl (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_evt(evt), .i_pwm(pwm), .o_cnt_clear(cnt_clear),
      .o_init_load(init_load), .o_buf_xfer(buf_xfer), .o_temp(temp), .o_crest_irq(crest_irq),
      .o_trough_irq(trough_irq), .o_adc_req(adc_req), .o_adc_delay_req(adc_dreq), .i_position(position),
      .i_shutdown(shutdown), .i_osc_stop(osc_stop), .o_gate(gate), .o_gate_oe(gate_oe));
   cpa_hall_model u_cpa_hall_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_step(step),
      .i_trip(trip), .o_position(position), .o_shutdown(shutdown));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge i_ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_ref_clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask
   task automatic pulse(input logic [7:0] e);
      @(posedge i_ref_clk);
      evt <= cpa_evt_t'(e | lv);
      @(posedge i_ref_clk);
      evt <= cpa_evt_t'(lv);
      #1;
   endtask
   task automatic settle;
      repeat (6) @(posedge i_ref_clk);
      #1;
   endtask

   task automatic t_regs;
      rd_reg(CPA_OFF_OUTC, 32'h3, "outc reset");
      rd_reg(CPA_OFF_ACC, 32'h1, "access reset");
      rd_reg(8'h3c, 32'h0, "unmapped");
      wr_reg(CPA_OFF_OUTC, 32'h7);
      rd_reg(CPA_OFF_OUTC, 32'h7, "outc write");
      wr_reg(CPA_OFF_OUTC, 32'h3);
      $display("test registers done");
   endtask
   task automatic t_clear;
      wr_reg(CPA_OFF_WAVE, 32'h2);
      pulse(EV_CREST);
      chk("clear on crest", 32'h1, cnt_clear);
      wr_reg(CPA_OFF_WAVE, 32'h0);
      pulse(EV_CREST);
      chk("no clear on crest", 32'h0, cnt_clear);
      wr_reg(CPA_OFF_SYNC, 32'h1);
      wr_reg(CPA_OFF_WAVE, 32'h1);
      pulse(EV_SYNC);
      chk("sync clear", 32'h1, cnt_clear);
      chk("init outside trough", 32'h1, init_load);
      lv = 8'h02;
      pulse(EV_SYNC);
      chk("init in trough", 32'h0, init_load);
      lv = 8'h03;
      pulse(EV_SYNC);
      chk("init in start period", 32'h1, init_load);
      lv = 8'h00;
      wr_reg(CPA_OFF_WAVE, 32'h0);
      wr_reg(CPA_OFF_SYNC, 32'h0);
      $display("test clearing done");
   endtask
   task automatic t_trig;
      pulse(EV_CREST);
      chk("adc disabled", 32'h0, adc_req);
      wr_reg(CPA_OFF_IEN, 32'h4);
      pulse(EV_CREST);
      chk("adc crest", 32'h1, adc_req);
      pulse(EV_TROUGH);
      chk("adc trough gated", 32'h0, adc_req);
      pulse(EV_OTHER);
      chk("adc other", 32'h1, adc_req);
      wr_reg(CPA_OFF_IEN, 32'hc);
      pulse(EV_TROUGH);
      chk("adc trough", 32'h1, adc_req);
      wr_reg(CPA_OFF_IEN, 32'h0);
      $display("test triggers done");
   endtask
   task automatic t_skip;
      wr_reg(CPA_OFF_SKIP, 32'hb0);
      wr_reg(CPA_OFF_BUFX, 32'h2);
      wr_reg(CPA_OFF_ADCR, 32'h1);
      wr_reg(CPA_OFF_IEN, 32'h3);
      for (int i = 1; i <= 6; i++) begin
         pulse(EV_CREST);
         chk("crest skip", 32'((i % 3) == 0), crest_irq);
      end
      pulse(EV_XFER);
      chk("linked xfer in window", 32'h1, buf_xfer);
      pulse(EV_DELAY);
      chk("delay in window", 32'h1, adc_dreq);
      pulse(EV_CREST);
      pulse(EV_XFER);
      chk("linked xfer closed", 32'h0, buf_xfer);
      pulse(EV_DELAY);
      chk("delay skipped", 32'h0, adc_dreq);
      wr_reg(CPA_OFF_ADCR, 32'h0);
      pulse(EV_DELAY);
      chk("delay unlinked", 32'h1, adc_dreq);
      pulse(EV_CREST);
      wr_reg(CPA_OFF_IEN, 32'h0);
      wr_reg(CPA_OFF_SKIP, 32'h0);
      wr_reg(CPA_OFF_SKIP, 32'hb0);
      wr_reg(CPA_OFF_IEN, 32'h1);
      for (int i = 1; i <= 3; i++) begin
         pulse(EV_CREST);
         chk("skip restart", 32'(i == 3), crest_irq);
      end
      wr_reg(CPA_OFF_IEN, 32'h0);
      wr_reg(CPA_OFF_SKIP, 32'h0);
      wr_reg(CPA_OFF_SKIP, 32'h0f);
      wr_reg(CPA_OFF_IEN, 32'h2);
      for (int i = 1; i <= 7; i++) begin
         pulse(EV_TROUGH);
         chk("trough skip seven", 32'(i == 7), trough_irq);
      end
      wr_reg(CPA_OFF_IEN, 32'h0);
      wr_reg(CPA_OFF_SKIP, 32'h0);
      $display("test skipping done");
   endtask
   task automatic t_buf;
      wr_reg(CPA_OFF_BUF, 32'h1234);
      wr_reg(CPA_OFF_BUFX, 32'h1);
      pulse(EV_XFER);
      chk("xfer off", 32'h0, buf_xfer);
      wr_reg(CPA_OFF_BUFX, 32'h2);
      pulse(EV_XFER);
      chk("linked no skip", 32'h0, buf_xfer);
      wr_reg(CPA_OFF_BUFX, 32'h0);
      pulse(EV_XFER);
      chk("xfer normal", 32'h1, buf_xfer);
      settle;
      chk("temp", 32'h1234, {16'h0, temp});
      wr_reg(CPA_OFF_ACC, 32'h0);
      wr_reg(CPA_OFF_GATE, 32'h0b);
      rd_reg(CPA_OFF_GATE, 32'h0, "gate locked read");
      wr_reg(CPA_OFF_BUF, 32'h5678);
      pulse(EV_XFER);
      settle;
      chk("buffer while locked", 32'h5678, {16'h0, temp});
      wr_reg(CPA_OFF_ACC, 32'h1);
      rd_reg(CPA_OFF_GATE, 32'h0, "gate write ignored");
      $display("test buffer and protection done");
   endtask
   task automatic t_hall;
      for (int i = 1; i <= 6; i++) begin
         @(posedge i_ref_clk);
         step <= 1'b1;
         @(posedge i_ref_clk);
         step <= 1'b0;
         settle;
         chk("hall pattern", {26'h0, HALL_TAB[i % 6]}, {26'h0, gate});
      end
      $display("test hall commutation done");
   endtask
   task automatic t_soft;
      wr_reg(CPA_OFF_GATE, 32'h0b);
      settle;
      chk("soft pattern 3", 32'h0c, {26'h0, gate});
      wr_reg(CPA_OFF_GATE, 32'h0d);
      settle;
      chk("soft pattern 5", 32'h22, {26'h0, gate});
      wr_reg(CPA_OFF_GATE, 32'h1b);
      settle;
      chk("chop low", 32'h04, {26'h0, gate});
      @(posedge i_ref_clk);
      pwm <= cpa_phase_t'(6'h38);
      settle;
      chk("chop high", 32'h0c, {26'h0, gate});
      wr_reg(CPA_OFF_GATE, 32'h0b);
      wr_reg(CPA_OFF_OUTC, 32'h0);
      settle;
      chk("inverted levels", 32'h33, {26'h0, gate});
      wr_reg(CPA_OFF_OUTC, 32'h3);
      wr_reg(CPA_OFF_GATE, 32'h0);
      $display("test software commutation done");
   endtask
   task automatic t_halt;
      chk("oe running", 32'h3f, {26'h0, gate_oe});
      @(posedge i_ref_clk);
      trip <= 1'b1;
      settle;
      chk("oe shutdown", 32'h0, {26'h0, gate_oe});
      @(posedge i_ref_clk);
      trip <= 1'b0;
      settle;
      chk("oe restored", 32'h3f, {26'h0, gate_oe});
      @(posedge i_ref_clk);
      osc_stop <= 1'b1;
      settle;
      chk("oe clock stop", 32'h0, {26'h0, gate_oe});
      $display("test output halt done");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      t_regs;
      t_clear;
      t_trig;
      t_skip;
      t_buf;
      t_hall;
      t_soft;
      t_halt;
      stop_test;
   end
   initial begin
      #500us;
      miscompares++;
      $display("watchdog expired");
      stop_test;
   end
endmodule
`default_nettype wire
